// ### pgc_checker.sv
`timescale 1ns/10ps
module pgc_checker #(
  parameter int LEVELS = pgc_pkg::LEVELS,
  parameter int CNT_W  = pgc_pkg::CNT_W
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rstn,
  // access request from the walker and pipeline
  input  wire logic                        i_req_valid,
  input  wire logic [LEVELS-1:0]           i_lvl_user,
  input  wire logic [LEVELS-1:0]           i_lvl_rw,
  input  wire logic [1:0]                  i_current_privilege_level,
  input  wire logic                        i_is_write,
  input  wire logic                        i_seg_fault,
  input  wire logic                        i_seg_stack,
  // decision
  output logic                             o_rsp_valid,
  output logic                             o_issue,
  output logic                             o_exception,
  output logic                             o_page_fault,
  output logic                             o_general_protection_fault,
  output logic                             o_stack_fault,
  output logic                             o_eff_user,
  output logic                             o_eff_rw,
  // register port
  input  wire logic [pgc_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [pgc_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic [pgc_pkg::DATA_W-1:0]       o_rdata,
  output logic                             o_irq
);

  localparam int NE = pgc_pkg::NUM_EV;
  localparam int LW = pgc_pkg::LAST_W;

  // control and interrupt registers
  logic [1:0]        ctrl;
  logic [NE-1:0]     stat;
  logic [NE-1:0]     mask;
  logic [LW-1:0]     last;
  logic [LEVELS-1:0] ro_levels_q; // read-only level snapshot for the fault record
  logic [CNT_W-1:0]  page_cnt;
  logic [CNT_W-1:0]  prot_cnt;
  logic [CNT_W-1:0]  ss_cnt;
  logic [CNT_W-1:0]  ok_cnt;

  // combinational decision wires
  logic              eff_user;
  logic              eff_rw;
  logic [LEVELS-1:0] ro_levels;
  logic              wp_on;
  logic              chk_on;
  logic              super_lvl;
  logic              priv_bad;
  logic              ro_page;
  logic              write_bad;
  logic              page_bad;
  logic              seg_bad;
  logic              page_hit;
  logic              prot_hit;
  logic              ss_hit;
  logic              any_fault;
  logic              go_issue;
  pgc_pkg::pgc_fault_t fault_cls;

  // register decode wires
  logic              sel_ctrl;
  logic              sel_stat;
  logic              sel_mask;
  logic              sel_last;
  logic              sel_pfct;
  logic              sel_gpct;
  logic              sel_ssct;
  logic              sel_okct;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              wr_mask;
  logic [NE-1:0]     ev_set;
  logic [NE-1:0]     ev_clr;
  logic [NE-1:0]     next_stat;
  logic [LW-1:0]     next_last;
  logic [pgc_pkg::DATA_W-1:0] next_rdata;
  logic              next_irq;

  // merge of the four levels lives in its own leaf
  pgc_level_merge #(
    .LEVELS (LEVELS)
  ) u_merge (
    .i_lvl_user  (i_lvl_user),
    .i_lvl_rw    (i_lvl_rw),
    .o_eff_user  (eff_user),
    .o_eff_rw    (eff_rw),
    .o_ro_levels (ro_levels)
  );

  // control bits steer the check
  assign wp_on  = ctrl[pgc_pkg::CTRL_WP_BIT];
  assign chk_on = ctrl[pgc_pkg::CTRL_EN_BIT];

  // privilege level 3 is user, the rest supervisor
  assign super_lvl = pgc_pkg::pgc_is_super(i_current_privilege_level); // RQ15

  // supervisor page closed to user code, whatever write protect says
  assign priv_bad = !eff_user && !super_lvl; // RQ2 RQ4 RQ7

  // combined access type read-only when any level says so
  assign ro_page = !eff_rw; // RQ5

  // user code never writes read-only pages; supervisor only when wp is set
  assign write_bad = (i_is_write == pgc_pkg::RW_WRITE) && ro_page
                     && (!super_lvl || wp_on); // RQ3 RQ5 RQ6 RQ8 RQ9 RQ17

  // page stage result, only meaningful once segment stage passed
  assign page_bad = chk_on && (priv_bad || write_bad); // RQ14

  // segment stage result comes first
  assign seg_bad = i_seg_fault; // RQ10

  // segment fault masks the page check entirely
  assign page_hit = i_req_valid && !seg_bad && page_bad; // RQ11 RQ14
  assign prot_hit = i_req_valid && seg_bad && !i_seg_stack; // RQ13
  assign ss_hit   = i_req_valid && seg_bad && i_seg_stack; // RQ13

  // any fault blocks the memory access
  assign any_fault = page_hit || prot_hit || ss_hit; // RQ12
  assign go_issue  = i_req_valid && !any_fault; // RQ12

  // fault class, segment classes take precedence
  assign fault_cls = prot_hit ? pgc_pkg::PGC_FLT_PROT :
                     ss_hit   ? pgc_pkg::PGC_FLT_SS :
                     page_hit ? pgc_pkg::PGC_FLT_PAGE :
                                pgc_pkg::PGC_FLT_NONE; // RQ10 RQ13

  // register address decode
  assign sel_ctrl = (i_addr == pgc_pkg::CTRL_OFS);
  assign sel_stat = (i_addr == pgc_pkg::STAT_OFS);
  assign sel_mask = (i_addr == pgc_pkg::MASK_OFS);
  assign sel_last = (i_addr == pgc_pkg::LAST_OFS);
  assign sel_pfct = (i_addr == pgc_pkg::PFCT_OFS);
  assign sel_gpct = (i_addr == pgc_pkg::GPCT_OFS);
  assign sel_ssct = (i_addr == pgc_pkg::SSCT_OFS);
  assign sel_okct = (i_addr == pgc_pkg::OKCT_OFS);
  assign wr_ctrl  = i_wr && sel_ctrl;
  assign wr_stat  = i_wr && sel_stat;
  assign wr_mask  = i_wr && sel_mask;

  // sticky events; a new event wins over a write-one clear
  assign ev_set    = {ss_hit, prot_hit, page_hit};
  assign ev_clr    = wr_stat ? i_wdata[NE-1:0] : {NE{1'b0}};
  assign next_stat = (stat & ~ev_clr) | ev_set;

  // snapshot of the faulting access for software
  assign next_last = {wp_on,
                      eff_rw,
                      eff_user,
                      i_is_write,
                      i_current_privilege_level,
                      fault_cls};

  // read mux, unmapped offsets read zero
  assign next_rdata =
      sel_ctrl ? {30'h0, ctrl} :
      sel_stat ? {29'h0, stat} :
      sel_mask ? {29'h0, mask} :
      sel_last ? {20'h0, ro_levels_q, last} :
      sel_pfct ? {16'h0, page_cnt} :
      sel_gpct ? {16'h0, prot_cnt} :
      sel_ssct ? {16'h0, ss_cnt} :
      sel_okct ? {16'h0, ok_cnt} :
                 32'h0;

  // interrupt level is built from the next status, so it changes on the same edge as the status register
  assign next_irq = |(next_stat & mask);

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= pgc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= i_wdata[1:0];
    end
  end

  // status holds events until software clears them
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      stat <= {NE{1'b0}};
    end else begin
      stat <= next_stat;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mask <= pgc_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask <= i_wdata[NE-1:0];
    end
  end

  // latest fault only; earlier ones are lost by design
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      last        <= {LW{1'b0}};
      ro_levels_q <= {LEVELS{1'b0}};
    end else if (any_fault) begin
      last        <= next_last;
      ro_levels_q <= ro_levels;
    end
  end

  // counters saturate instead of wrapping so a storm stays visible
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      page_cnt <= {CNT_W{1'b0}};
      prot_cnt <= {CNT_W{1'b0}};
      ss_cnt <= {CNT_W{1'b0}};
      ok_cnt <= {CNT_W{1'b0}};
    end else begin
      page_cnt <= pgc_pkg::pgc_sat_inc(page_cnt, page_hit);
      prot_cnt <= pgc_pkg::pgc_sat_inc(prot_cnt, prot_hit);
      ss_cnt <= pgc_pkg::pgc_sat_inc(ss_cnt, ss_hit);
      ok_cnt <= pgc_pkg::pgc_sat_inc(ok_cnt, go_issue);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= {pgc_pkg::DATA_W{1'b0}};
    end else begin
      o_rdata <= i_rd ? next_rdata : {pgc_pkg::DATA_W{1'b0}};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

  // decision formed combinationally in the request cycle, held one cycle
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rsp_valid                <= 1'b0;
      o_issue                    <= 1'b0;
      o_exception                <= 1'b0;
      o_page_fault               <= 1'b0;
      o_general_protection_fault <= 1'b0;
      o_stack_fault              <= 1'b0;
    end else begin
      o_rsp_valid                <= i_req_valid; // RQ18
      o_issue                    <= go_issue; // RQ12
      o_exception                <= any_fault; // RQ12
      o_page_fault               <= page_hit; // RQ14
      o_general_protection_fault <= prot_hit; // RQ13
      o_stack_fault              <= ss_hit; // RQ13
    end
  end

  // effective protection shown for every request
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_eff_user <= 1'b0;
      o_eff_rw   <= 1'b0;
    end else if (i_req_valid) begin
      o_eff_user <= eff_user; // RQ1
      o_eff_rw   <= eff_rw; // RQ1
    end
  end

endmodule : pgc_checker

// ### pgc_pkg.sv
// What this block does
// RQ1 - combine class and access bits from all four table levels into one protection
// RQ2 - without write protect, any supervisor level makes a supervisor page; level 3 refused
// RQ3 - without write protect, supervisor pages are read/write even if all levels read-only
// RQ4 - all levels user makes a user page, open to every privilege level
// RQ5 - user page read-only for user code if any level read-only
// RQ6 - without write protect, supervisor code writes read-only user pages freely
// RQ7 - with write protect, supervisor pages stay closed to level 3
// RQ8 - with write protect, supervisor page writable only when all levels read/write
// RQ9 - with write protect, supervisor writes to read-only user pages refused
// RQ10 - segment check ordered first, page check after it, per access
// RQ11 - a segment violation suppresses the page check and its fault
// RQ12 - any violation raises an exception and the access is not issued
// RQ13 - segment violations report general protection or stack fault, never page fault
// RQ14 - page stage violations report page fault
// RQ15 - level 3 is user; levels 0, 1 and 2 together are supervisor
// RQ16 - access bit 1 means read/write, 0 means read-only
// RQ17 - with write protect, any write to a read-only page gives page fault
// RQ18 - decision is formed in the cycle the request inputs are presented
package pgc_pkg;

  localparam int LEVELS = 4;
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int NUM_EV = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] MASK_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] LAST_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] PFCT_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] GPCT_OFS = 5'h14;
  localparam logic [ADDR_W-1:0] SSCT_OFS = 5'h18;
  localparam logic [ADDR_W-1:0] OKCT_OFS = 5'h1c;

  // control register fields of system_control_register
  localparam int CTRL_WP_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;

  // event bits shared by status and mask
  localparam int EV_PAGE = 0;
  localparam int EV_PROT = 1;
  localparam int EV_SS = 2;
  localparam logic [NUM_EV-1:0] MASK_RST = 3'h0;

  // last-fault record layout
  localparam int LAST_CLS_LSB = 0;
  localparam int LAST_LVL_LSB = 2;
  localparam int LAST_WR_BIT  = 4;
  localparam int LAST_EU_BIT  = 5;
  localparam int LAST_ER_BIT  = 6;
  localparam int LAST_WP_BIT  = 7;
  localparam int LAST_W       = 8;

  localparam logic [1:0] LVL_USER = 2'h3;
  localparam logic       RW_WRITE = 1'h1;

  typedef enum logic [1:0] {
    PGC_FLT_NONE,
    PGC_FLT_PROT,
    PGC_FLT_SS,
    PGC_FLT_PAGE
  } pgc_fault_t;

  // levels 0..2 count as supervisor
  function automatic logic pgc_is_super(input logic [1:0] priv);
    pgc_is_super = (priv != LVL_USER);
  endfunction : pgc_is_super

  // saturating event counter step
  function automatic logic [CNT_W-1:0] pgc_sat_inc(input logic [CNT_W-1:0] c,
                                                   input logic            en);
    pgc_sat_inc = (en && (c != {CNT_W{1'b1}})) ? c + 16'h0001 : c;
  endfunction : pgc_sat_inc

endpackage : pgc_pkg

// ### pgc_level_merge.sv
`timescale 1ns/10ps
module pgc_level_merge #(
  parameter int LEVELS = pgc_pkg::LEVELS
) (
  input  wire logic [LEVELS-1:0] i_lvl_user,
  input  wire logic [LEVELS-1:0] i_lvl_rw,
  output logic                   o_eff_user,
  output logic                   o_eff_rw,
  output logic [LEVELS-1:0]      o_ro_levels
);

  // one supervisor level anywhere makes the page supervisor
  assign o_eff_user  = &i_lvl_user; // RQ1 RQ2 RQ4
  // rw bit 1 grants write; every level must grant it
  assign o_eff_rw    = &i_lvl_rw; // RQ1 RQ5 RQ8 RQ16
  // kept for the fault record, shows which levels were read-only
  assign o_ro_levels = ~i_lvl_rw; // RQ16

endmodule : pgc_level_merge

// ### pgc_properties.sv
`timescale 1ns/10ps
module pgc_props #(
  parameter int LEVELS = 4
) (
  input wire logic                       i_clk_sys,
  input wire logic                       i_rstn,
  input wire logic                       i_req_valid,
  input wire logic [LEVELS-1:0]          i_lvl_user,
  input wire logic [LEVELS-1:0]          i_lvl_rw,
  input wire logic [1:0]                 i_current_privilege_level,
  input wire logic                       i_is_write,
  input wire logic                       i_seg_fault,
  input wire logic                       i_seg_stack,
  input wire logic                       o_rsp_valid,
  input wire logic                       o_issue,
  input wire logic                       o_exception,
  input wire logic                       o_page_fault,
  input wire logic                       o_general_protection_fault,
  input wire logic                       o_stack_fault,
  input wire logic                       o_eff_user,
  input wire logic                       o_eff_rw,
  input wire logic [pgc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [pgc_pkg::DATA_W-1:0] i_wdata,
  input wire logic                       i_wr
);
  logic [1:0] ctl;
  logic       page_exp;
  logic       usr;
  // mirror of the control word so the page verdict can be predicted
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl <= pgc_pkg::CTRL_RST;
    end else if (i_wr && i_addr == pgc_pkg::CTRL_OFS) begin
      ctl <= i_wdata[1:0];
    end
  end
  // expected page verdict; write protect only bites supervisor writes
  assign usr = (i_current_privilege_level == pgc_pkg::LVL_USER);
  assign page_exp = ctl[pgc_pkg::CTRL_EN_BIT] && ((usr && !(&i_lvl_user)) ||
                    (i_is_write && !(&i_lvl_rw) && (usr || ctl[pgc_pkg::CTRL_WP_BIT])));
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  // long expressions kept in named properties so each label line stays short
  property p_page_decide;
    i_req_valid && !i_seg_fault |=> o_page_fault == $past(page_exp);
  endproperty
  property p_seg_first;
    i_req_valid && i_seg_fault |=> o_exception && !o_page_fault && !o_issue;
  endproperty
  property p_seg_class;
    i_req_valid && i_seg_fault |=> o_stack_fault == $past(i_seg_stack) &&
                                   o_general_protection_fault != $past(i_seg_stack);
  endproperty
  property p_page_class;
    o_page_fault |-> o_exception && !o_stack_fault && !o_general_protection_fault;
  endproperty
  property p_level_merge;
    i_req_valid |=> o_eff_user == &$past(i_lvl_user) && o_eff_rw == &$past(i_lvl_rw);
  endproperty
  a_rsp_one_late: assert property (i_req_valid |=> o_rsp_valid)
    else $error("no response one cycle after request");
  a_idle_quiet: assert property (!i_req_valid |=> !o_rsp_valid && !o_issue && !o_exception)
    else $error("decision without request");
  a_page_decide: assert property (p_page_decide)
    else $error("page verdict wrong");
  a_seg_first: assert property (p_seg_first)
    else $error("segment fault not taken first");
  a_seg_class: assert property (p_seg_class)
    else $error("segment fault class wrong");
  a_page_class: assert property (p_page_class)
    else $error("page fault class wrong");
  a_issue_clean: assert property (o_rsp_valid |-> o_issue != o_exception)
    else $error("issue and exception disagree");
  a_level_merge: assert property (p_level_merge)
    else $error("merged protection wrong");
  c_seg: cover property (o_stack_fault);
  c_page: cover property (o_page_fault && ctl[pgc_pkg::CTRL_WP_BIT]);
  c_issue: cover property (o_issue && ctl[pgc_pkg::CTRL_WP_BIT]);
  c_unchecked: cover property (o_issue && !ctl[pgc_pkg::CTRL_EN_BIT]);
endmodule : pgc_props

bind pgc_checker pgc_props #(.LEVELS(LEVELS)) u_props (.*);

// ### pgc_walker.sv
`timescale 1ns/10ps
module pgc_walker (
  input  wire logic       i_clk_sys,
  output logic            o_req_valid,
  output logic [3:0]      o_lvl_user,
  output logic [3:0]      o_lvl_rw,
  output logic [1:0]      o_current_privilege_level,
  output logic [2:0]      o_kind
);
  // quiet lines at time zero
  initial begin
    o_req_valid = 1'b0;
    o_lvl_user = 4'h0;
    o_lvl_rw = 4'h0;
    o_current_privilege_level = 2'h0;
    o_kind = 3'h0;
  end
  // one access launched after an edge; kind is write, segment fault, stack
  task automatic send(input logic [3:0] u, r, input logic [1:0] c, input logic [2:0] k);
    @(posedge i_clk_sys);
    o_req_valid <= 1'b1;
    o_lvl_user <= u;
    o_lvl_rw <= r;
    o_current_privilege_level <= c;
    o_kind <= k;
  endtask : send
  // released fields flip so a stale value never passes for a live one
  task automatic quiet;
    @(posedge i_clk_sys);
    o_req_valid <= 1'b0;
    o_lvl_user <= ~o_lvl_user;
    o_lvl_rw <= ~o_lvl_rw;
    o_current_privilege_level <= ~o_current_privilege_level;
    o_kind <= ~o_kind;
  endtask : quiet
endmodule : pgc_walker

// ### page_permission_checker_bench.sv
`timescale 1ns/10ps
module page_permission_checker_bench;
  typedef struct packed {
    logic [3:0] u, rw;
    logic [1:0] priv;
    logic [3:0] m;
    logic [3:0] ex;
  } pgc_row_t;
  logic        clk, rstn, req_valid, wr, rd, rsp, iss, exc, pgf, gpf, ss, eu, erw, irq;
  logic [3:0]  lvl_user, lvl_rw;
  logic [1:0]  priv;
  logic [2:0]  kind;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  int          fails, check_count;
  pgc_row_t    r;
  // m = write, segment fault, stack, write protect; ex = issue, pf, gp, ss
  pgc_row_t rows [14] = '{
    {4'hb, 4'hf, 2'h3, 4'h0, 4'h4}, {4'hb, 4'hf, 2'h2, 4'h0, 4'h8},
    {4'h0, 4'h0, 2'h0, 4'h8, 4'h8}, {4'hf, 4'hf, 2'h3, 4'h8, 4'h8},
    {4'hf, 4'he, 2'h3, 4'h8, 4'h4}, {4'hf, 4'he, 2'h3, 4'h0, 4'h8},
    {4'hf, 4'h7, 2'h1, 4'h8, 4'h8}, {4'h7, 4'hf, 2'h3, 4'h1, 4'h4},
    {4'h0, 4'hd, 2'h0, 4'h9, 4'h4}, {4'h0, 4'hf, 2'h0, 4'h9, 4'h8},
    {4'hf, 4'hb, 2'h2, 4'h9, 4'h4}, {4'hf, 4'hb, 2'h2, 4'h1, 4'h8},
    {4'h0, 4'h0, 2'h3, 4'hc, 4'h2}, {4'h0, 4'h0, 2'h3, 4'he, 4'h1}};
  pgc_walker w (.i_clk_sys(clk), .o_req_valid(req_valid), .o_lvl_user(lvl_user),
    .o_lvl_rw(lvl_rw), .o_current_privilege_level(priv), .o_kind(kind));
  pgc_checker dut (.i_clk_sys(clk), .i_rstn(rstn), .i_req_valid(req_valid),
    .i_lvl_user(lvl_user), .i_lvl_rw(lvl_rw), .i_current_privilege_level(priv),
    .i_is_write(kind[2]), .i_seg_fault(kind[1]), .i_seg_stack(kind[0]),
    .o_rsp_valid(rsp), .o_issue(iss), .o_exception(exc), .o_page_fault(pgf),
    .o_general_protection_fault(gpf), .o_stack_fault(ss), .o_eff_user(eu),
    .o_eff_rw(erw), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_irq(irq));
  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check("register", rdata, exp);
  endtask : rd_chk
  // irq sampled one edge after the write lands
  task automatic irq_chk(input logic exp);
    @(posedge clk);
    #1 check("irq", {31'h0, irq}, {31'h0, exp});
  endtask : irq_chk
  task automatic give_verdict;
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  // cut a hang short well beyond the expected run
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  initial begin
    {rstn, wr, rd, addr, wdata, fails, check_count} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[k]) begin
      r = rows[k];
      wr_reg(pgc_pkg::CTRL_OFS, {31'h1, r.m[0]});
      w.send(r.u, r.rw, r.priv, r.m[3:1]);
      w.quiet();
      #1 check("response", {31'h0, rsp}, 32'h1);
      check("issue", {30'h0, exc, iss}, {30'h0, !r.ex[3], r.ex[3]});
      check("page", {31'h0, pgf}, {31'h0, r.ex[2]});
      check("segment", {30'h0, gpf, ss}, {30'h0, r.ex[1:0]});
      check("merge", {30'h0, eu, erw}, {30'h0, &r.u, &r.rw});
    end
    // last fault: stack class, level 3 write, every level supervisor and read-only
    rd_chk(pgc_pkg::LAST_OFS, 32'hf1e);
    rd_chk(pgc_pkg::PFCT_OFS, 32'h5);
    rd_chk(pgc_pkg::GPCT_OFS, 32'h1);
    rd_chk(pgc_pkg::SSCT_OFS, 32'h1);
    rd_chk(pgc_pkg::OKCT_OFS, 32'h7);
    rd_chk(pgc_pkg::STAT_OFS, 32'h7);
    irq_chk(1'b0);
    wr_reg(pgc_pkg::MASK_OFS, 32'h1);
    irq_chk(1'b1);
    wr_reg(pgc_pkg::STAT_OFS, 32'h1);
    irq_chk(1'b0);
    rd_chk(pgc_pkg::STAT_OFS, 32'h6);
    wr_reg(pgc_pkg::MASK_OFS, 32'h7);
    irq_chk(1'b1);
    // back to back: the second request rides the first one's answer cycle
    w.send(4'hb, 4'hf, 2'h3, 3'h0);
    w.send(4'hf, 4'hf, 2'h3, 3'h4);
    #1 check("first", {30'h0, pgf, iss}, 32'h2);
    w.quiet();
    #1 check("second", {30'h0, pgf, iss}, 32'h1);
    rd_chk(5'h02, 32'h0);
    // page check switched off: a user access to a supervisor page goes through
    wr_reg(pgc_pkg::CTRL_OFS, 32'h0);
    w.send(4'hb, 4'hf, 2'h3, 3'h0);
    w.quiet();
    #1 check("unchecked", {30'h0, pgf, iss}, 32'h1);
    @(posedge clk);
    rstn <= 1'b0;
    irq_chk(1'b0);
    @(posedge clk);
    rstn <= 1'b1;
    rd_chk(pgc_pkg::CTRL_OFS, 32'h2);
    rd_chk(pgc_pkg::MASK_OFS, 32'h0);
    rd_chk(pgc_pkg::OKCT_OFS, 32'h0);
    give_verdict();
  end
endmodule : page_permission_checker_bench
